//--- inc/tx8_pkg.sv
// constants and carrier types for the transmit 8b/10b encoder
package tx8_pkg;

   // ***********************************
   // apb register map
   // ***********************************
   localparam int         TX8_ADDR_W      = 12;
   localparam logic [11:0] TX8_CTRL_ADDR  = 12'h000;
   localparam logic [11:0] TX8_STAT_ADDR  = 12'h004;
   localparam int         TX8_CTRL_ENC    = 0;
   localparam int         TX8_CTRL_WIDTH  = 1;
   localparam logic [1:0] TX8_CTRL_RESET  = 2'h3;
   localparam int         TX8_STAT_RD     = 0;
   localparam int         TX8_STAT_KERR   = 2;
   localparam int         TX8_STAT_LEVEL  = 4;

   // ***********************************
   // code constants
   // ***********************************
   localparam int         TX8_LANES       = 2;
   localparam int         TX8_CODE_W      = 10;
   localparam int         TX8_BUF_DEPTH   = 2;
   localparam logic [4:0] TX8_X_K28       = 5'h1C;
   localparam logic [5:0] TX8_K28_6B      = 6'h0F;
   localparam logic [3:0] TX8_ALT7_4B     = 4'h7;
   localparam logic [7:0] TX8_K23_7       = 8'hF7;
   localparam logic [7:0] TX8_K27_7       = 8'hFB;
   localparam logic [7:0] TX8_K29_7       = 8'hFD;
   localparam logic [7:0] TX8_K30_7       = 8'hFE;
   localparam logic [2:0] TX8_Y_ALT       = 3'h7;
   localparam logic [2:0] TX8_Y_FLIP      = 3'h3;
   localparam logic [4:0] TX8_X_FLIP      = 5'h07;

   // ***********************************
   // carriers
   // ***********************************
   typedef struct packed {
      logic [1:0]  bypass;
      logic [1:0]  disp_mode;
      logic [1:0]  disp_val;
      logic [1:0]  ctrl_flag;
      logic [15:0] data;
   } tx8_word_s;

   typedef struct packed {
      logic [19:0] code;
      logic [1:0]  kerr;
      logic [1:0]  rd;
   } tx8_code_s;

endpackage

//--- core/tx8_encoder.sv
// transmit 8b/10b encoder for two byte lanes with apb control and two-entry input buffer
`timescale 1ns/10ps

module tx8_encoder (
   // clock and reset
   input  wire logic                           clk_sys_in,
   input  wire logic                           rst_in,
   // apb slave
   input  wire logic                           psel_in,
   input  wire logic                           penable_in,
   input  wire logic                           pwrite_in,
   input  wire logic [tx8_pkg::TX8_ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]                    pwdata_in,
   output logic      [31:0]                    prdata_out,
   output logic                                pready_out,
   output logic                                pslverr_out,
   // parallel transmit word in
   input  wire tx8_pkg::tx8_word_s             tx_word_in,
   input  wire logic                           tx_valid_in,
   output logic                                tx_ready_out,
   // encoded characters out
   output logic      [19:0]                    code_out,
   output logic                                code_valid_out,
   input  wire logic                           code_ready_in,
   // per-character status
   output logic      [1:0]                     control_char_error_out,
   output logic      [1:0]                     running_disparity_status_out
);

   // ***********************************
   // code tables
   // ***********************************
   function automatic logic [5:0] lut6(input logic [4:0] x);
      unique case (x)
         5'h00: lut6 = 6'h27;
         5'h01: lut6 = 6'h1D;
         5'h02: lut6 = 6'h2D;
         5'h03: lut6 = 6'h31;
         5'h04: lut6 = 6'h35;
         5'h05: lut6 = 6'h29;
         5'h06: lut6 = 6'h19;
         5'h07: lut6 = 6'h38;
         5'h08: lut6 = 6'h39;
         5'h09: lut6 = 6'h25;
         5'h0A: lut6 = 6'h15;
         5'h0B: lut6 = 6'h34;
         5'h0C: lut6 = 6'h0D;
         5'h0D: lut6 = 6'h2C;
         5'h0E: lut6 = 6'h1C;
         5'h0F: lut6 = 6'h17;
         5'h10: lut6 = 6'h1B;
         5'h11: lut6 = 6'h23;
         5'h12: lut6 = 6'h13;
         5'h13: lut6 = 6'h32;
         5'h14: lut6 = 6'h0B;
         5'h15: lut6 = 6'h2A;
         5'h16: lut6 = 6'h1A;
         5'h17: lut6 = 6'h3A;
         5'h18: lut6 = 6'h33;
         5'h19: lut6 = 6'h26;
         5'h1A: lut6 = 6'h16;
         5'h1B: lut6 = 6'h36;
         5'h1C: lut6 = 6'h0E;
         5'h1D: lut6 = 6'h2E;
         5'h1E: lut6 = 6'h1E;
         5'h1F: lut6 = 6'h2B;
      endcase
   endfunction

   function automatic logic [3:0] lut4(input logic [2:0] y);
      unique case (y)
         3'h0: lut4 = 4'hB;
         3'h1: lut4 = 4'h9;
         3'h2: lut4 = 4'h5;
         3'h3: lut4 = 4'hC;
         3'h4: lut4 = 4'hD;
         3'h5: lut4 = 4'hA;
         3'h6: lut4 = 4'h6;
         3'h7: lut4 = 4'hE;
      endcase
   endfunction

   // ***********************************
   // one character: {rd_out, kerr, code}
   // ***********************************
   // tables hold the negative-disparity form; the positive form is the complement for unbalanced codes and for x.07 and y.3
   function automatic logic [11:0] enc_char(
      input logic [7:0] d,
      input logic       k,
      input logic       rd
   );
      logic [5:0] s6;
      logic [3:0] s4;
      logic [4:0] x;
      logic [2:0] y;
      logic       rdm;
      logic       k28;
      logic       kval;
      logic       alt;
      logic       rdo;
      logic [9:0] abc;
      logic [9:0] rev;
      x    = d[4:0];
      y    = d[7:5];
      k28  = k && (x == tx8_pkg::TX8_X_K28);
      kval = k28 || (d == tx8_pkg::TX8_K23_7) || (d == tx8_pkg::TX8_K27_7)
             || (d == tx8_pkg::TX8_K29_7) || (d == tx8_pkg::TX8_K30_7);
      s6 = k28 ? tx8_pkg::TX8_K28_6B : lut6(x);
      if (rd && (($countones(s6) != 3) || (x == tx8_pkg::TX8_X_FLIP))) begin
         s6 = ~s6;
      end
      rdm = rd ^ ($countones(s6) != 3);
      // alternate x.7 avoids a run of five in data; valid K x.7 always uses it
      alt = (y == tx8_pkg::TX8_Y_ALT) && ((k && kval)
            || (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14))
            || (rdm && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
      s4 = alt ? tx8_pkg::TX8_ALT7_4B : lut4(y);
      if (rdm && (($countones(s4) != 2) || (y == tx8_pkg::TX8_Y_FLIP))) begin
         s4 = ~s4;
      end else if (k28 && !rdm && ($countones(s4) == 2) && (y != tx8_pkg::TX8_Y_FLIP)) begin
         s4 = ~s4;
      end
      rdo = rdm ^ ($countones(s4) != 2);
      abc = {s6, s4};
      // serializer sends bit 0 first, so code bit a must land there
      for (int i = 0; i < tx8_pkg::TX8_CODE_W; i++) begin
         rev[i] = abc[tx8_pkg::TX8_CODE_W-1-i];
      end
      enc_char = {rdo, k && !kval, rev};
   endfunction

   // ***********************************
   // apb registers
   // ***********************************
   logic [1:0]  ctrl;
   logic [1:0]  next_ctrl;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [1:0]  fifo_count;
   logic        apb_hit;
   logic        apb_map;

   // one wait state so read data comes from a flop
   always_comb begin
      apb_hit      = psel_in && penable_in && pready_out;
      apb_map      = (paddr_in == tx8_pkg::TX8_CTRL_ADDR) || (paddr_in == tx8_pkg::TX8_STAT_ADDR);
      next_ctrl    = ctrl;
      next_pready  = psel_in && penable_in && !pready_out;
      next_pslverr = next_pready && !apb_map;
      next_prdata  = prdata_out;
      if (apb_hit && pwrite_in && (paddr_in == tx8_pkg::TX8_CTRL_ADDR)) begin
         next_ctrl = pwdata_in[1:0];
      end
      if (next_pready) begin
         next_prdata = 32'h0000_0000;
         if (paddr_in == tx8_pkg::TX8_CTRL_ADDR) begin
            next_prdata[1:0] = ctrl;
         end else if (paddr_in == tx8_pkg::TX8_STAT_ADDR) begin
            next_prdata[tx8_pkg::TX8_STAT_RD+:2]    = running_disparity_status_out;
            next_prdata[tx8_pkg::TX8_STAT_KERR+:2]  = control_char_error_out;
            next_prdata[tx8_pkg::TX8_STAT_LEVEL+:2] = fifo_count;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ctrl        <= tx8_pkg::TX8_CTRL_RESET;
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         ctrl        <= next_ctrl;
         prdata_out  <= next_prdata;
         pready_out  <= next_pready;
         pslverr_out <= next_pslverr;
      end
   end

   // ***********************************
   // two-entry input buffer
   // ***********************************
   tx8_pkg::tx8_word_s buf_mem [tx8_pkg::TX8_BUF_DEPTH];
   tx8_pkg::tx8_word_s next_mem [tx8_pkg::TX8_BUF_DEPTH];
   logic       wr_ptr;
   logic       rd_ptr;
   logic       next_wr_ptr;
   logic       next_rd_ptr;
   logic [1:0] next_count;
   logic       next_tx_ready;
   logic       push;
   logic       pop;

   always_comb begin
      push          = tx_valid_in && tx_ready_out;
      pop           = (fifo_count != 2'h0) && (!code_valid_out || code_ready_in);
      next_mem      = buf_mem;
      next_wr_ptr   = wr_ptr;
      next_rd_ptr   = rd_ptr;
      if (push) begin
         next_mem[wr_ptr] = tx_word_in;
         next_wr_ptr      = !wr_ptr;
      end
      if (pop) begin
         next_rd_ptr = !rd_ptr;
      end
      next_count    = fifo_count + {1'b0, push} - {1'b0, pop};
      // ready is registered, so it must look at next fill, not current
      next_tx_ready = next_count != 2'h2;
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wr_ptr       <= 1'b0;
         rd_ptr       <= 1'b0;
         fifo_count   <= 2'h0;
         tx_ready_out <= 1'b0;
      end else begin
         wr_ptr       <= next_wr_ptr;
         rd_ptr       <= next_rd_ptr;
         fifo_count   <= next_count;
         tx_ready_out <= next_tx_ready;
      end
      buf_mem <= next_mem;
   end

   // ***********************************
   // encoding stage
   // ***********************************
   tx8_pkg::tx8_word_s head;
   tx8_pkg::tx8_code_s enc;
   logic        run_rd;
   logic        next_run_rd;
   logic        enc_on;
   logic        lane_rd;
   logic        rd_use;
   logic [11:0] ch;
   logic [19:0] next_code;
   logic [1:0]  next_kerr;
   logic [1:0]  next_rd_stat;
   logic        next_code_valid;

   always_comb begin
      head   = buf_mem[rd_ptr];
      // width select must be high for the encoder to run
      enc_on = ctrl[tx8_pkg::TX8_CTRL_ENC] && ctrl[tx8_pkg::TX8_CTRL_WIDTH];
      lane_rd = run_rd;
      rd_use  = 1'b0;
      ch      = 12'h000;
      enc     = '0;
      // low lane first so its disparity feeds the high lane
      for (int i = 0; i < tx8_pkg::TX8_LANES; i++) begin
         if (!enc_on || head.bypass[i]) begin
            // raw path: mode and value extend the byte to ten bits
            enc.code[i*10+:10] = {head.disp_mode[i], head.disp_val[i], head.data[i*8+:8]};
         end else begin
            rd_use = head.disp_mode[i] ? head.disp_val[i] : (lane_rd ^ head.disp_val[i]);
            ch = enc_char(head.data[i*8+:8], head.ctrl_flag[i], rd_use);
            enc.code[i*10+:10] = ch[9:0];
            lane_rd = ch[11];
            enc.kerr[1-i] = ch[10];
         end
         enc.rd[1-i] = lane_rd;
      end
      next_run_rd     = pop ? lane_rd : run_rd;
      next_code       = pop ? enc.code : code_out;
      next_kerr       = pop ? enc.kerr : control_char_error_out;
      // status trails the accepted word by the buffer and output stage
      next_rd_stat    = pop ? enc.rd : running_disparity_status_out;
      next_code_valid = pop || (code_valid_out && !code_ready_in);
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         run_rd                       <= 1'b0;
         code_out                     <= 20'h0_0000;
         control_char_error_out       <= 2'h0;
         running_disparity_status_out <= 2'h0;
         code_valid_out               <= 1'b0;
      end else begin
         run_rd                       <= next_run_rd;
         code_out                     <= next_code;
         control_char_error_out       <= next_kerr;
         running_disparity_status_out <= next_rd_stat;
         code_valid_out               <= next_code_valid;
      end
   end

endmodule

//--- tb/tx8_encoder_properties.sv
// checker of stream, status and bus timing at the encoder ports
`timescale 1ns/10ps
module tx8_encoder_properties (
   // clock and reset
   input wire logic        clk_sys_in,
   input wire logic        rst_in,
   // apb answer
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // stream
   input wire logic        tx_valid_in,
   input wire logic        tx_ready_out,
   input wire logic [19:0] code_out,
   input wire logic        code_valid_out,
   input wire logic        code_ready_in,
   input wire logic [1:0]  control_char_error_out,
   input wire logic [1:0]  running_disparity_status_out
);
   // ***********************************
   // properties
   // ***********************************
   wire took  = tx_valid_in && tx_ready_out;
   wire stall = code_valid_out && !code_ready_in;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   AST_RESET_QUIET: assert property ($fell(rst_in) |-> !tx_ready_out && !code_valid_out ##1 tx_ready_out)
      else $error("stream outputs wrong after reset");
   AST_CODE_HOLD: assert property (stall |=> code_valid_out && $stable(code_out))
      else $error("code changed while stalled");
   AST_STAT_HOLD: assert property (stall |=> $stable(control_char_error_out) && $stable(running_disparity_status_out))
      else $error("status changed while stalled");
   AST_RISE_LAT: assert property ($rose(code_valid_out) |-> $past(took, 2))
      else $error("output valid without word two cycles back");
   AST_TAKE_BOUND: assert property (took |-> ##[1:40] code_valid_out)
      else $error("accepted word never reached output");
   // a full buffer is only legal while the output stage holds a character
   AST_NO_LOSS: assert property (!tx_ready_out && !$past(rst_in) |-> code_valid_out)
      else $error("input refused with output idle");
   AST_APB_ONE: assert property (pready_out |=> !pready_out)
      else $error("ready stood two cycles");
   AST_APB_ERR: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
endmodule

bind tx8_encoder tx8_encoder_properties i_props (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out), .code_out(code_out),
   .code_valid_out(code_valid_out), .code_ready_in(code_ready_in),
   .control_char_error_out(control_char_error_out),
   .running_disparity_status_out(running_disparity_status_out));

//--- tb/tx8_sink.sv
// partner sink that takes encoded characters, with optional stalls
`timescale 1ns/10ps
module tx8_sink (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   // characters from the encoder
   input  wire logic [19:0] code_in,
   input  wire logic        valid_in,
   input  wire logic [1:0]  kerr_in,
   input  wire logic [1:0]  rd_in,
   output logic             ready_out,
   // pacing
   input  wire logic        slow_in,
   input  wire logic        hold_in
);
   logic [1:0]  cnt = 2'h0;
   logic [23:0] got[$];
   initial ready_out = 1'b0;
   // slow pacing takes one word in four so outputs must stand under stall
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         cnt <= 2'h0;
         ready_out <= 1'b0;
      end else begin
         cnt <= cnt + 2'h1;
         ready_out <= !hold_in && (!slow_in || cnt == 2'h0);
         if (valid_in && ready_out) begin
            got.push_back({code_in, kerr_in, rd_in});
         end
      end
   end
endmodule

//--- tb/tx8_encoder_tb.sv
// self-checking bench for the transmit encoder
`timescale 1ns/10ps
module tx8_encoder_tb;
   // ***********************************
   // reference tables, a bit is msb
   // ***********************************
   localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38, 6'h39, 6'h25,
      6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [31:0] T4 = 32'hE6ADC59B;
   localparam logic [31:0] K4 = 32'h86A23594;
   localparam logic [95:0] KC = 96'hFEFDFBF7FCDCBC9C7C5C3C1C;
   logic               clk_sys_in = 1'b0, rst_in = 1'b1, slow = 1'b0, hold = 1'b0;
   logic               psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0]        paddr_in = 12'h0;
   logic [31:0]        pwdata_in = 32'h0, prdata_out, q;
   logic               pready_out, pslverr_out, tx_valid_in = 1'b0, tx_ready_out, e;
   tx8_pkg::tx8_word_s tx_word_in = '0;
   logic [19:0]        code_out;
   logic               code_valid_out, code_ready_in;
   logic [1:0]         control_char_error_out, running_disparity_status_out;
   int                 err_count = 0, samples_checked = 0, cyc = 0, i;
   logic               rd = 1'b0, en = 1'b1;
   logic [3:0]         st = 4'h0;
   logic [23:0]        exp_q[$];

   tx8_encoder i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .tx_word_in(tx_word_in), .tx_valid_in(tx_valid_in),
      .tx_ready_out(tx_ready_out), .code_out(code_out), .code_valid_out(code_valid_out),
      .code_ready_in(code_ready_in), .control_char_error_out(control_char_error_out),
      .running_disparity_status_out(running_disparity_status_out));
   tx8_sink i_sink (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .code_in(code_out), .valid_in(code_valid_out),
      .kerr_in(control_char_error_out), .rd_in(running_disparity_status_out), .ready_out(code_ready_in),
      .slow_in(slow), .hold_in(hold));

   always #10 clk_sys_in = ~clk_sys_in;

   function automatic logic kok(input logic [7:0] d);
      return d[4:0] == 5'h1C || (d[7:5] == 3'h7 && d[4:0] inside {5'h17, 5'h1B, 5'h1D, 5'h1E});
   endfunction

   // returns {disparity after, abcdei fghj}
   function automatic logic [10:0] enc(input logic [7:0] d, input logic k, input logic r0);
      logic [5:0] s;
      logic [3:0] f;
      logic       r, k28;
      k28 = k && kok(d) && d[4:0] == 5'h1C;
      s = k28 ? 6'h0F : T6[d[4:0]];
      r = r0 ^ ($countones(s) != 3);
      if (r0 && ($countones(s) != 3 || d[4:0] == 5'h07)) s = ~s;
      if (k28) begin
         f = r ? K4[d[7:5]*4 +: 4] : ~K4[d[7:5]*4 +: 4];
      end else begin
         f = (d[7:5] == 3'h7 && ((k && kok(d)) || (!r && d[4:0] inside {5'h11, 5'h12, 5'h14})
              || (r && d[4:0] inside {5'h0B, 5'h0D, 5'h0E}))) ? 4'h7 : T4[d[7:5]*4 +: 4];
         if (r && ($countones(f) != 2 || d[7:5] == 3'h3)) f = ~f;
      end
      return {r ^ ($countones(f) != 2), s, f};
   endfunction

   task check(input string n, input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      // no answer time is assumed; only the bench timeout ends a hung wait
      do begin
         @(posedge clk_sys_in);
      end while (!pready_out);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask

   // leaves valid high so words can follow back to back
   task send(input logic [1:0] bp, input logic [1:0] md, input logic [1:0] vl, input logic [1:0] fl,
             input logic [15:0] dt);
      int l;
      logic [10:0] x;
      logic [19:0] c;
      logic [1:0]  ke, rs;
      for (l = 0; l < 2; l++) begin
         if (!en || bp[l]) begin
            c[l*10 +: 10] = {md[l], vl[l], dt[l*8 +: 8]};
            ke[1-l] = 1'b0;
         end else begin
            x = enc(dt[l*8 +: 8], fl[l], md[l] ? vl[l] : rd ^ vl[l]);
            for (int b = 0; b < 10; b++) begin
               c[l*10+b] = x[9-b];
            end
            rd = x[10];
            ke[1-l] = fl[l] && !kok(dt[l*8 +: 8]);
         end
         rs[1-l] = rd;
      end
      exp_q.push_back({c, ke, rs});
      st = {ke, rs};
      tx_word_in <= '{bp, md, vl, fl, dt};
      tx_valid_in <= 1'b1;
      do begin
         @(posedge clk_sys_in);
      end while (!tx_ready_out);
   endtask

   task flush(input string t);
      int n;
      tx_valid_in <= 1'b0;
      n = 0;
      while (i_sink.got.size() < exp_q.size() && n < 3000) begin
         @(posedge clk_sys_in);
         n++;
      end
      check("word count", 32'(i_sink.got.size()), 32'(exp_q.size()));
      while (exp_q.size() > 0 && i_sink.got.size() > 0) begin
         check("character", {8'h0, i_sink.got.pop_front()}, {8'h0, exp_q.pop_front()});
      end
      $display("test %s done", t);
   endtask

   task end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      repeat (16) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      apb(1'b0, tx8_pkg::TX8_CTRL_ADDR, 32'h0);
      check("ctrl reset", q, 32'h3);
      apb(1'b1, 12'h008, 32'hFFFFFFFF);
      check("unmapped error", {31'h0, e}, 32'h1);
      apb(1'b1, tx8_pkg::TX8_STAT_ADDR, 32'h3F);
      apb(1'b0, tx8_pkg::TX8_STAT_ADDR, 32'h0);
      check("status read only", q, 32'h0);
      apb(1'b0, tx8_pkg::TX8_CTRL_ADDR, 32'h0);
      check("ctrl kept", q, 32'h3);
      $display("test registers done");
      slow <= 1'b1;
      for (i = 0; i < 128; i++) send(2'h0, i[1:0], i[3:2], 2'h0, {i[6:0], 1'b1, i[6:0], 1'b0});
      flush("data sweep");
      slow <= 1'b0;
      for (i = 0; i < 6; i++) send(2'h0, 2'h0, 2'h0, 2'h3, KC[i*16 +: 16]);
      send(2'h0, 2'h0, 2'h0, 2'h3, 16'hFF00);
      send(2'h0, 2'h0, 2'h0, 2'h1, 16'h3CBC);
      flush("control characters");
      apb(1'b0, tx8_pkg::TX8_STAT_ADDR, 32'h0);
      check("status after control", {28'h0, q[3:0]}, {28'h0, st});
      hold <= 1'b1;
      for (i = 0; i < 3; i++) send(i[1:0], 2'h2, 2'h1, 2'h0, 16'hA55A ^ 16'(i));
      tx_valid_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      check("ready when full", {31'h0, tx_ready_out}, 32'h0);
      apb(1'b0, tx8_pkg::TX8_STAT_ADDR, 32'h0);
      check("fill level", {30'h0, q[5:4]}, 32'h2);
      hold <= 1'b0;
      send(2'h3, 2'h1, 2'h2, 2'h0, 16'h0FF0);
      flush("bypass");
      apb(1'b1, tx8_pkg::TX8_CTRL_ADDR, 32'h2);
      en = 1'b0;
      apb(1'b0, tx8_pkg::TX8_CTRL_ADDR, 32'h0);
      check("ctrl write", q, 32'h2);
      send(2'h0, 2'h1, 2'h2, 2'h3, 16'h1234);
      flush("encoder off");
      apb(1'b1, tx8_pkg::TX8_CTRL_ADDR, 32'h3);
      en = 1'b1;
      send(2'h2, 2'h0, 2'h0, 2'h0, 16'hBCB5);
      flush("encoder on");
      end_sim();
   end
endmodule
